/* hdl/umf_pkg.sv */
// package for the serial mode and transmit flow control block
// assumes one 200 MHz clock, byte-wide register port, active-low async reset
package umf_pkg;
   // ==========================================================
   // register layout
   localparam logic [7:0] UMF_PRIMARY_RESET = 8'h00;
   localparam logic [7:0] UMF_SECONDARY_RESET = 8'h00;
   localparam int UMF_RX_RTS_BIT = 7;
   localparam int UMF_PM_LSB = 3;
   localparam int UMF_PT_BIT = 2;
   localparam int UMF_BC_LSB = 0;
   localparam int UMF_CM_LSB = 6;
   localparam int UMF_TX_RTS_BIT = 5;
   localparam int UMF_TX_CTS_BIT = 4;
   // ==========================================================
   // encodings
   localparam logic [1:0] UMF_PM_WITH = 2'h0;
   localparam logic [1:0] UMF_PM_FORCE = 2'h1;
   localparam logic [1:0] UMF_PM_NONE = 2'h2;
   localparam logic [1:0] UMF_PM_MULTI = 2'h3;
   localparam logic [1:0] UMF_CM_NORMAL = 2'h0;
   localparam logic [1:0] UMF_CM_ECHO = 2'h1;
   localparam logic [1:0] UMF_CM_LOCAL = 2'h2;
   localparam logic [1:0] UMF_CM_REMOTE = 2'h3;
   // ==========================================================
   // timing
   localparam int UMF_CLOCK_MHZ = 200;
   localparam int UMF_BAUD = 115200;
   localparam int UMF_BIT_CYCLES = (UMF_CLOCK_MHZ * 1000000) / UMF_BAUD;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic [1:0] parity_mode_field;
      logic parity_type_bit;
      logic [1:0] char_len;
   } umf_frame_t;
   typedef enum logic [3:0] {
      UMF_IDLE = 4'h1,
      UMF_SHIFT = 4'h2,
      UMF_RTS_WAIT = 4'h4,
      UMF_CTS_WAIT = 4'h8
   } umf_tx_state_t;
endpackage

/* hdl/umf_mode_flow.sv */
// one channel: mode registers, pointer, tx framer with cts/rts flow
// assumes byte register port, remote device on txd/rxd/cts pins
`timescale 1ns/10ps
module umf_mode_flow #(
   parameter int BIT_CYCLES = umf_pkg::UMF_BIT_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic reg_sel_mode,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic ptr_reset,
   input wire logic modem_mode,
   input wire logic rts_set,
   output logic [7:0] reg_rdata,
   output logic ptr_secondary,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_parity_err,
   output logic rx_addr_char,
   input wire logic rxd,
   input wire logic cts_n,
   output logic txd,
   output logic rts_n,
   output logic [1:0] channel_mode,
   output logic rx_rts_active
);
   // ==========================================================
   // mode registers and pointer
   logic [7:0] primary_reg, secondary_reg;
   logic ptr_reg;
   logic [7:0] rdata_reg;
   wire access = reg_sel_mode & (reg_wr | reg_rd);
   wire wr_primary = reg_sel_mode & reg_wr & ~ptr_reg;
   wire wr_secondary = reg_sel_mode & reg_wr & ptr_reg;
   wire [7:0] sel_data = ptr_reg ? secondary_reg : primary_reg;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         primary_reg <= umf_pkg::UMF_PRIMARY_RESET;
         secondary_reg <= umf_pkg::UMF_SECONDARY_RESET;
         ptr_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end
      else
      begin
         if (wr_primary)
            primary_reg <= reg_wdata;
         if (wr_secondary)
            secondary_reg <= reg_wdata;
         // pointer only moves forward from primary; secondary holds it
         if (ptr_reset)
            ptr_reg <= 1'b0;
         else if (access && !ptr_reg)
            ptr_reg <= 1'b1;
         if (reg_sel_mode && reg_rd)
            rdata_reg <= sel_data;
      end
   end
   assign reg_rdata = rdata_reg;
   assign ptr_secondary = ptr_reg;
   // ==========================================================
   // field decode
   wire [1:0] pm = primary_reg[umf_pkg::UMF_PM_LSB +: 2];
   wire pt = primary_reg[umf_pkg::UMF_PT_BIT] & ~modem_mode;
   wire [1:0] bc = modem_mode ? 2'h3 : primary_reg[umf_pkg::UMF_BC_LSB +: 2];
   wire rx_rts_raw = primary_reg[umf_pkg::UMF_RX_RTS_BIT];
   wire tx_rts_raw = secondary_reg[umf_pkg::UMF_TX_RTS_BIT];
   wire both_rts = rx_rts_raw & tx_rts_raw;
   wire tx_rts_en = tx_rts_raw & ~both_rts & ~modem_mode;
   wire cts_en = secondary_reg[umf_pkg::UMF_TX_CTS_BIT] & ~modem_mode;
   wire [1:0] cm = secondary_reg[umf_pkg::UMF_CM_LSB +: 2];
   wire [3:0] nbits = 4'h5 + {2'h0, bc};
   wire has_par = modem_mode ? 1'b0 : (pm != umf_pkg::UMF_PM_NONE);
   wire [7:0] dmask = 8'hFF >> (4'h8 - nbits);
   function automatic logic par_of(input logic [7:0] d, input logic [1:0] m, input logic t);
      case (m)
         umf_pkg::UMF_PM_WITH: par_of = ^d ^ t;
         umf_pkg::UMF_PM_FORCE: par_of = t;
         default: par_of = t;
      endcase
   endfunction
   // ==========================================================
   // pin synchronisers, three stages
   logic [2:0] rxd_s, cts_s;
   logic cts_asserted_reg, rxd_reg;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxd_s <= 3'h7;
         cts_s <= 3'h7;
         cts_asserted_reg <= 1'b0;
         rxd_reg <= 1'b1;
      end
      else
      begin
         rxd_s <= {rxd_s[1:0], rxd};
         cts_s <= {cts_s[1:0], cts_n};
         if (cts_s[2] == cts_s[1])
            cts_asserted_reg <= ~cts_s[2];
         if (rxd_s[2] == rxd_s[1])
            rxd_reg <= rxd_s[2];
      end
   end
   // ==========================================================
   // two-entry buffer ahead of the framer
   logic [7:0] buf_mem [2];
   logic buf_wp, buf_rp;
   logic [1:0] buf_cnt;
   wire buf_push = tx_valid & (buf_cnt != 2'h2);
   wire buf_empty = (buf_cnt == 2'h0);
   logic buf_pop;
   assign tx_ready = (buf_cnt != 2'h2);
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_wp <= 1'b0;
         buf_rp <= 1'b0;
         buf_cnt <= 2'h0;
      end
      else
      begin
         if (buf_push)
            buf_wp <= ~buf_wp;
         if (buf_pop)
            buf_rp <= ~buf_rp;
         buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end
   always_ff @(posedge clock)
   begin
      if (buf_push)
         buf_mem[buf_wp] <= tx_data;
   end
   // ==========================================================
   // transmitter
   umf_pkg::umf_tx_state_t st_reg;
   logic [10:0] sh_reg;
   logic [3:0] left_reg;
   logic [15:0] bcnt_reg;
   logic rts_reg, txd_reg;
   wire bit_tick = (bcnt_reg == 16'(BIT_CYCLES - 1));
   wire cts_ok = ~cts_en | cts_asserted_reg;
   wire [7:0] head = buf_mem[buf_rp] & dmask;
   // frame lsb first: start, data, parity if enabled, one stop; idle ones fill the rest
   wire [10:0] par_pos = 11'h001 << (nbits + 4'h1);
   wire par_bit = par_of(head, pm, pt);
   wire [10:0] frame_ones = {2'b00, head, 1'b0} | (11'h7FF << (nbits + 4'h1));
   wire [10:0] frame_fix = (frame_ones & ~(has_par ? par_pos : 11'h000))
                           | ((has_par && par_bit) ? par_pos : 11'h000);
   wire [3:0] frame_len = nbits + 4'h2 + {3'h0, has_par};
   assign buf_pop = (st_reg == umf_pkg::UMF_IDLE || st_reg == umf_pkg::UMF_RTS_WAIT
                    || st_reg == umf_pkg::UMF_CTS_WAIT) && !buf_empty && cts_ok;
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= umf_pkg::UMF_IDLE;
         sh_reg <= 11'h7FF;
         left_reg <= 4'h0;
         bcnt_reg <= 16'h0000;
         rts_reg <= 1'b0;
         txd_reg <= 1'b1;
      end
      else
      begin
         bcnt_reg <= bit_tick ? 16'h0000 : bcnt_reg + 16'h0001;
         if (rts_set)
            rts_reg <= 1'b1;
         unique case (st_reg)
            umf_pkg::UMF_IDLE, umf_pkg::UMF_CTS_WAIT, umf_pkg::UMF_RTS_WAIT:
            begin
               txd_reg <= 1'b1;
               if (buf_pop)
               begin
                  sh_reg <= frame_fix;
                  left_reg <= frame_len;
                  bcnt_reg <= 16'h0000;
                  txd_reg <= 1'b0;
                  st_reg <= umf_pkg::UMF_SHIFT;
               end
               else if (!buf_empty)
                  st_reg <= umf_pkg::UMF_CTS_WAIT;
               else if (st_reg == umf_pkg::UMF_RTS_WAIT && bit_tick)
               begin
                  if (tx_rts_en && !rts_set)
                     rts_reg <= 1'b0;
                  st_reg <= umf_pkg::UMF_IDLE;
               end
            end
            umf_pkg::UMF_SHIFT:
            begin
               // frame is latched; cts is no longer looked at
               if (bit_tick)
               begin
                  sh_reg <= {1'b1, sh_reg[10:1]};
                  txd_reg <= sh_reg[1];
                  left_reg <= left_reg - 4'h1;
                  if (left_reg == 4'h1)
                  begin
                     txd_reg <= 1'b1;
                     st_reg <= tx_rts_en ? umf_pkg::UMF_RTS_WAIT : umf_pkg::UMF_IDLE;
                  end
               end
            end
         endcase
      end
   end
   // ==========================================================
   // receiver and loop selection
   logic rx_line;
   logic [7:0] rx_sh_reg;
   logic [3:0] rx_left_reg;
   logic [15:0] rx_cnt_reg;
   logic rx_busy_reg, rxv_reg, rxpe_reg, rxa_reg, rxpar_reg;
   logic [7:0] rxd_out_reg;
   logic txd_pin_reg;
   assign rx_line = (cm == umf_pkg::UMF_CM_LOCAL) ? txd_reg : rxd_reg;
   wire rx_mid = (rx_cnt_reg == 16'(BIT_CYCLES - 1));
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_busy_reg <= 1'b0;
         rx_sh_reg <= 8'h00;
         rx_left_reg <= 4'h0;
         rx_cnt_reg <= 16'h0000;
         rxv_reg <= 1'b0;
         rxpe_reg <= 1'b0;
         rxa_reg <= 1'b0;
         rxpar_reg <= 1'b0;
         rxd_out_reg <= 8'h00;
         txd_pin_reg <= 1'b1;
      end
      else
      begin
         rxv_reg <= 1'b0;
         // echo and remote loop return the received line instead of the framer
         txd_pin_reg <= (cm == umf_pkg::UMF_CM_ECHO || cm == umf_pkg::UMF_CM_REMOTE)
                        ? rxd_reg : (cm == umf_pkg::UMF_CM_LOCAL ? 1'b1 : txd_reg);
         if (!rx_busy_reg)
         begin
            if (!rx_line)
            begin
               rx_busy_reg <= 1'b1;
               rx_cnt_reg <= 16'(BIT_CYCLES / 2);
               // start sample is shifted in too and later pushed out of the bottom
               rx_left_reg <= nbits + {3'h0, has_par} + 4'h2;
            end
         end
         else
         begin
            rx_cnt_reg <= rx_mid ? 16'h0000 : rx_cnt_reg + 16'h0001;
            if (rx_mid)
            begin
               rx_left_reg <= rx_left_reg - 4'h1;
               if (rx_left_reg > {3'h0, has_par} + 4'h1)
                  rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
               else if (rx_left_reg == 4'h2 && has_par)
                  rxpar_reg <= rx_line;
               else
               begin
                  rx_busy_reg <= 1'b0;
                  rxv_reg <= (cm != umf_pkg::UMF_CM_REMOTE);
                  rxd_out_reg <= (rx_sh_reg >> (4'h8 - nbits)) & dmask;
                  rxpe_reg <= has_par && pm != umf_pkg::UMF_PM_MULTI
                     && (rxpar_reg != par_of((rx_sh_reg >> (4'h8 - nbits)) & dmask, pm, pt));
                  rxa_reg <= has_par && pm == umf_pkg::UMF_PM_MULTI && rxpar_reg;
               end
            end
         end
      end
   end
   assign txd = txd_pin_reg;
   assign rts_n = ~rts_reg;
   assign channel_mode = secondary_reg[umf_pkg::UMF_CM_LSB +: 2];
   assign rx_rts_active = primary_reg[umf_pkg::UMF_RX_RTS_BIT] & ~tx_rts_raw & ~modem_mode;
   assign rx_valid = rxv_reg;
   assign rx_data = rxd_out_reg;
   assign rx_parity_err = rxpe_reg;
   assign rx_addr_char = rxa_reg;
   // ==========================================================
   // checks
   ptr_adv_a: assert property (@(posedge clock) disable iff (!rst_n)
      access && !ptr_reg && !ptr_reset |=> ptr_reg) else $error("pointer did not advance");
   ptr_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      ptr_reg && !ptr_reset |=> ptr_reg) else $error("secondary access moved pointer");
   sec_guard_a: assert property (@(posedge clock) disable iff (!rst_n)
      !ptr_reg |=> $stable(secondary_reg)) else $error("secondary written off pointer");
   ptr_clr_a: assert property (@(posedge clock) disable iff (!rst_n)
      ptr_reset |=> !ptr_reg) else $error("pointer reset ignored");
   cts_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      cts_en && !cts_asserted_reg && st_reg != umf_pkg::UMF_SHIFT |=> txd_reg) else $error("sent without cts");
   shift_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
      st_reg == umf_pkg::UMF_SHIFT && !bit_tick |=> st_reg == umf_pkg::UMF_SHIFT) else $error("character broken");
   rts_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
      !tx_rts_en && rts_reg |=> rts_reg) else $error("rts dropped without control");
   both_rts_a: assert property (@(posedge clock) disable iff (!rst_n)
      both_rts |-> !tx_rts_en && !rx_rts_active) else $error("dual rts not disabled");
endmodule // umf_mode_flow

/* dv/umf_remote_model.sv */
// remote serial device: captures frames from txd, sends frames on rxd
// assumes the block's clock and an idle-high line on both wires
`timescale 1ns/10ps
module umf_remote_model #(
   parameter int BIT_CYCLES = 16
) (
   input wire logic clock,
   input wire logic txd,
   output logic rxd
);
   // ==========================================================
   // receive side: ten mid-bit samples after each start bit
   logic [9:0] frames[$];
   logic [9:0] cap;
   initial
   begin
      forever
      begin
         @(negedge txd);
         repeat (BIT_CYCLES / 2) @(posedge clock);
         for (int i = 0; i < 10; i++)
         begin
            repeat (BIT_CYCLES) @(posedge clock);
            cap[i] = txd;
         end
         frames.push_back(cap);
      end
   end
   // ==========================================================
   // send side: line returns to its idle high level after the frame
   initial rxd = 1'b1;
   task automatic send(input logic [9:0] bits);
      @(negedge clock);
      rxd = 1'b0;
      repeat (BIT_CYCLES) @(negedge clock);
      for (int i = 0; i < 10; i++)
      begin
         rxd = bits[i];
         repeat (BIT_CYCLES) @(negedge clock);
      end
      rxd = 1'b1;
   endtask
endmodule // umf_remote_model

/* dv/umf_mode_flow_tb_top.sv */
// self-checking bench: mode pointer, framing, channel modes, cts and rts flow
// assumes the block with a 16-cycle bit time and the remote model on its pins
`timescale 1ns/10ps
module umf_mode_flow_tb_top;
   localparam int BITC = 16;
   logic clock, rst_n, reg_sel_mode, reg_wr, reg_rd, ptr_reset, modem_mode, rts_set;
   logic ptr_secondary, tx_valid, tx_ready, rx_valid, rx_parity_err, rx_addr_char;
   logic rxd, cts_n, txd, rts_n, rx_rts_active, rx_perr;
   logic [1:0] channel_mode;
   logic [7:0] reg_wdata, reg_rdata, tx_data, rx_data, rx_last, pri;
   logic [7:0] rnd = 8'h08;
   logic [7:0] q[$];
   int failures = 0;
   int compares = 0;
   int rx_cnt = 0;
   int n;
   umf_mode_flow #(.BIT_CYCLES(BITC)) i_umf_mode_flow (
      .clock(clock), .rst_n(rst_n), .reg_sel_mode(reg_sel_mode), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .ptr_reset(ptr_reset),
      .modem_mode(modem_mode), .rts_set(rts_set), .reg_rdata(reg_rdata),
      .ptr_secondary(ptr_secondary), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_parity_err(rx_parity_err), .rx_addr_char(rx_addr_char), .rxd(rxd),
      .cts_n(cts_n), .txd(txd), .rts_n(rts_n), .channel_mode(channel_mode),
      .rx_rts_active(rx_rts_active));
   umf_remote_model #(.BIT_CYCLES(BITC)) i_umf_remote_model (
      .clock(clock), .txd(txd), .rxd(rxd));
   // ==========================================================
   // helpers
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   // ten samples after the start bit, padded with idle ones
   function automatic logic [9:0] frame_of(input logic [7:0] v, input logic [7:0] p,
                                           input logic md);
      logic [9:0] f;
      int nb;
      logic [1:0] pm;
      f = 10'h3FF;
      nb = md ? 8 : 5 + int'(p[1:0]);
      pm = md ? umf_pkg::UMF_PM_NONE : p[4:3];
      for (int i = 0; i < nb; i++)
         f[i] = v[i];
      if (pm == umf_pkg::UMF_PM_WITH)
         f[nb] = (^(v & ~(8'hFF << nb))) ^ p[2];
      else if (pm != umf_pkg::UMF_PM_NONE)
         f[nb] = p[2];
      return f;
   endfunction
   task automatic report_and_stop;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic reg_access(input logic wr, input logic [7:0] v);
      @(negedge clock);
      reg_sel_mode = 1'b1;
      reg_wr = wr;
      reg_rd = ~wr;
      reg_wdata = v;
      @(negedge clock);
      reg_sel_mode = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   endtask
   task automatic ptr_home;
      @(negedge clock);
      ptr_reset = 1'b1;
      @(negedge clock);
      ptr_reset = 1'b0;
   endtask
   // called after the last frame is captured; its stop bit may still be shifting
   task automatic cfg(input logic [7:0] p, input logic [7:0] s);
      ptr_home();
      reg_access(1'b1, p);
      reg_access(1'b1, s);
      pri = p;
   endtask
   task automatic set_rts;
      @(negedge clock);
      rts_set = 1'b1;
      @(negedge clock);
      rts_set = 1'b0;
   endtask
   task automatic push(input logic [7:0] v);
      @(negedge clock);
      tx_valid = 1'b1;
      tx_data = v;
      @(negedge clock);
      tx_valid = 1'b0;
   endtask
   // bounded wait on captured frames or on received characters
   task automatic wait_for(input int cnt, input logic rxside);
      int k;
      k = 0;
      while ((rxside ? rx_cnt : i_umf_remote_model.frames.size()) < cnt && k < 5000)
      begin
         @(negedge clock);
         k++;
      end
      if (k == 5000)
      begin
         failures++;
         $display("wrong value at %0t: wait ran out", $time);
         report_and_stop();
      end
   endtask
   task automatic tx_one(input logic [7:0] v, input logic [9:0] e);
      push(v);
      wait_for(1, 1'b0);
      check(i_umf_remote_model.frames[0] === e, "tx frame");
      i_umf_remote_model.frames.delete();
   endtask
   always @(posedge clock)
      if (rx_valid === 1'b1)
      begin
         rx_cnt++;
         rx_last = rx_data;
         rx_perr = rx_parity_err;
      end
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // ==========================================================
   // main sequence
   initial
   begin
      {rst_n, reg_sel_mode, reg_wr, reg_rd, ptr_reset, modem_mode, rts_set, tx_valid} = '0;
      reg_wdata = 8'h00;
      tx_data = 8'h00;
      cts_n = 1'b0;
      repeat (16) @(negedge clock);
      rst_n = 1'b1;
      check(ptr_secondary === 1'b0 && txd === 1'b1 && rts_n === 1'b1, "reset");
      reg_access(1'b0, 8'h00);
      check(reg_rdata === umf_pkg::UMF_PRIMARY_RESET && ptr_secondary === 1'b1, "ptr");
      reg_access(1'b1, 8'h30);
      reg_access(1'b0, 8'h00);
      check(reg_rdata === 8'h30 && ptr_secondary === 1'b1, "secondary");
      cfg(8'h1B, 8'h00);
      reg_access(1'b0, 8'h00);
      check(reg_rdata === 8'h00, "second kept");
      ptr_home();
      check(ptr_secondary === 1'b0, "ptr reset");
      reg_access(1'b0, 8'h00);
      check(reg_rdata === 8'h1B, "primary");
      for (int cm = 0; cm < 4; cm++)
      begin
         cfg(8'h03, {cm[1:0], 6'h00});
         check(channel_mode === cm[1:0], "mode field");
      end
      for (int i = 0; i < 14; i++)
      begin
         rnd = lfsr(rnd);
         cfg(i < 8 ? {3'h0, i[2:0], 2'h3} : {3'h0, rnd[4:0]}, 8'h00);
         rnd = lfsr(rnd);
         tx_one(rnd, frame_of(rnd, pri, 1'b0));
      end
      modem_mode = 1'b1;
      cts_n = 1'b1;
      cfg(8'h04, 8'h10);
      tx_one(8'hC5, frame_of(8'hC5, 8'h00, 1'b1));
      modem_mode = 1'b0;
      cfg(8'h03, 8'h00);
      tx_one(8'h6E, frame_of(8'h6E, pri, 1'b0));
      cfg(8'h03, 8'h30);
      n = 0;
      while (tx_ready === 1'b1 && n < 4)
      begin
         rnd = lfsr(rnd);
         q.push_back(rnd);
         push(rnd);
         n++;
      end
      check(tx_ready === 1'b0, "buffer full");
      repeat (4 * BITC) @(negedge clock);
      check(txd === 1'b1 && i_umf_remote_model.frames.size() == 0, "cts hold");
      cts_n = 1'b0;
      repeat (2 * BITC) @(negedge clock);
      cts_n = 1'b1;
      repeat (12 * BITC) @(negedge clock);
      check(i_umf_remote_model.frames.size() == 1, "one frame");
      cts_n = 1'b0;
      wait_for(n, 1'b0);
      for (int j = 0; j < n; j++)
         check(i_umf_remote_model.frames[j] === frame_of(q[j], pri, 1'b0), "order");
      i_umf_remote_model.frames.delete();
      for (int r = 0; r < 3; r++)
      begin
         cfg(r == 2 ? 8'h83 : 8'h03, r == 0 ? 8'h00 : 8'h20);
         set_rts();
         check(rts_n === 1'b0, "rts set");
         tx_one(8'hA5, frame_of(8'hA5, pri, 1'b0));
         repeat (BITC / 4) @(negedge clock);
         check(rts_n === 1'b0, "rts early");
         repeat (2 * BITC) @(negedge clock);
         check(rts_n === (r == 1), "rts after");
      end
      check(rx_rts_active === 1'b0, "rts both");
      cfg(8'h03, 8'h00);
      for (int b = 0; b < 2; b++)
      begin
         n = rx_cnt;
         i_umf_remote_model.send(frame_of(8'h5A, pri, 1'b0) ^ {1'b0, b[0], 8'h00});
         wait_for(n + 1, 1'b1);
         check(rx_last === 8'h5A && rx_perr === b[0], "rx parity");
      end
      cfg(8'h03, 8'h80);
      n = rx_cnt;
      push(8'h3C);
      wait_for(n + 1, 1'b1);
      check(rx_last === 8'h3C && i_umf_remote_model.frames.size() == 0, "local");
      for (int m = 1; m < 4; m += 2)
      begin
         cfg(8'h03, {m[1:0], 6'h00});
         n = rx_cnt;
         i_umf_remote_model.send(frame_of(8'h96, pri, 1'b0));
         wait_for(1, 1'b0);
         check(i_umf_remote_model.frames[0] === frame_of(8'h96, pri, 1'b0), "echo");
         check(m == 1 || rx_cnt == n, "remote rx");
         i_umf_remote_model.frames.delete();
      end
      report_and_stop();
   end
endmodule // umf_mode_flow_tb_top
